/* File: hw/plci_pkg.sv */
package plci_pkg;
	// Byte offsets, index times four
	localparam logic [7:0] OFS_BASIC = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ID1 = 8'h08;
	localparam logic [7:0] OFS_ID2 = 8'h0c;
	localparam logic [7:0] OFS_ADV = 8'h10;
	localparam logic [7:0] OFS_PARTNER = 8'h14;
	localparam logic [7:0] OFS_EXP = 8'h18;
	localparam logic [7:0] OFS_MODE = 8'h44;
	localparam logic [7:0] OFS_SPECIAL = 8'h6c;
	localparam logic [7:0] OFS_FLAGS = 8'h74;
	localparam logic [7:0] OFS_ENABLES = 8'h78;
	localparam logic [7:0] OFS_FPAUSE = 8'h80;
	localparam logic [7:0] OFS_SYSIRQ = 8'h84;
	// Field positions
	localparam int BC_SPEED = 13;
	localparam int BC_AN = 12;
	localparam int BC_PDOWN = 11;
	localparam int BC_RESTART = 9;
	localparam int BC_DUPLEX = 8;
	localparam int ADV_SYM = 10;
	localparam int ADV_ASYM = 11;
	localparam int AB_100FD = 8;
	localparam int AB_100HD = 7;
	localparam int AB_10FD = 6;
	localparam int AB_10HD = 5;
	localparam int LP_RFAULT = 13;
	localparam int MODE_EDPD = 13;
	localparam int MODE_ENERGY = 1;
	localparam int SP_OVR = 15;
	localparam int SP_AUTO = 14;
	localparam int SP_MAN = 13;
	localparam int IRQ_ENERGY = 7;
	localparam int IRQ_ANDONE = 6;
	localparam int IRQ_RFAULT = 5;
	localparam int IRQ_LDOWN = 4;
	localparam int IRQ_LPACK = 3;
	localparam int IRQ_PDFAULT = 2;
	localparam int IRQ_PAGE = 1;
	localparam int FP_SEL = 0;
	localparam int SYS_PORT1_BIT = 26;
	localparam int SYS_PORT2_BIT = 27;
	// Reset values and masks
	localparam logic [15:0] BASIC_RST = 16'h3100;
	localparam logic [15:0] BASIC_WMASK = 16'h3b00;
	localparam logic [15:0] ADV_RST = 16'h01e1;
	localparam logic [15:0] ADV_WMASK = 16'h0de0;
	localparam logic [15:0] SP_WMASK = 16'he000;
	localparam logic [15:0] EN_WMASK = 16'h00fe;
	localparam logic [15:0] STATUS_FIX = 16'h7809;
	localparam logic [15:0] UNMAPPED = 16'hffff;
	// Break-link interval
	localparam int unsigned BREAK_LINK_MS = 1200;
	localparam int unsigned CLK_KHZ = 200000;
	localparam int unsigned BREAK_LINK_CYC = BREAK_LINK_MS * CLK_KHZ;
	// Negotiation states
	typedef enum logic [2:0] {
		AN_OFF, AN_BREAK, AN_ABILITY, AN_ACK, AN_LINK, AN_PDOWN
	} plci_an_type;
endpackage : plci_pkg

/* File: hw/plci_port.sv */
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module plci_port #(
	parameter int unsigned BREAK_CYCLES = plci_pkg::BREAK_LINK_CYC,
	parameter int PORT_INDEX = 1,
	// Identifier words, values arbitrary
	parameter logic [15:0] ID_HI = 16'h0000,
	parameter logic [15:0] ID_LO = 16'h0010
) (
	input wire logic ref_clk, // 200 MHz clock
	input wire logic srst, // Sync reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic strap_sym_pause, // Pause strap
	input wire logic strap_asym_pause, // Asym pause strap
	input wire logic strap_auto_mdix, // Auto crossover strap
	input wire logic strap_manual_mdix, // Manual cross strap
	input wire logic line_energy_seen, // Energy, async
	input wire logic line_signal_ok, // Signal, async
	input wire logic flp_page_valid, // Burst word pulse
	input wire logic [15:0] flp_page_word, // Burst word
	input wire logic flp_ack_seen, // Partner ack pulse
	input wire logic pd_sym100, // 100M symbols seen
	input wire logic pd_nlp10, // 10M link pulses seen
	input wire logic pd_fault, // Detection fault pulse
	input wire logic mac_tx_en, // MAC transmit enable
	input wire logic [3:0] mac_txd, // MAC transmit nibble
	input wire logic line_rx_dv, // Line receive valid
	input wire logic [3:0] line_rxd, // Line receive nibble
	output logic line_tx_en, // To line transmit
	output logic [3:0] line_txd, // To line nibble
	output logic mii_rx_dv, // To MAC valid
	output logic [3:0] mii_rxd, // To MAC nibble
	output logic mii_crs, // Carrier sense
	output logic mii_col, // Collision
	output logic rxclk_recovered, // Receive clock source
	output logic speed_100, // Operating speed
	output logic full_duplex, // Operating duplex
	output logic link_up, // Link established
	output logic port_fc_tx, // Pause transmit enable
	output logic port_fc_rx, // Pause receive enable
	output logic auto_mdix_en, // Auto crossover on
	output logic mdix_cross, // Manual crossover state
	output logic port_power_down, // Port powered down
	output logic port_irq // Interrupt summary
);
	import plci_pkg::*;

	localparam logic [31:0] BRK_LAST = 32'(BREAK_CYCLES - 1);
	localparam int SYS_BIT = (PORT_INDEX == 1) ? SYS_PORT1_BIT
		: SYS_PORT2_BIT;

	// Whole port state
	typedef struct packed {
		plci_an_type an; // Negotiation state
		logic [31:0] cnt; // Break timer
		logic [15:0] basic; // Basic control
		logic [15:0] adv; // Advertisement
		logic [15:0] partner; // Partner ability
		logic [15:0] mode; // Mode control
		logic [15:0] special; // Special control
		logic [15:0] enables; // Interrupt mask
		logic [7:0] flags; // Interrupt flags
		logic [2:0] fpause; // Forced pause cfg
		logic exp_lp_an; // Partner negotiates
		logic exp_page; // Page received
		logic exp_pdf; // Detection fault
		logic spd; // 100M
		logic fdx; // Full duplex
		logic link; // Link up
		logic ancomp; // Negotiation done
		logic txfc; // Pause tx state
		logic rxfc; // Pause rx state
		logic [2:0] s_en; // Energy sync
		logic [2:0] s_sig; // Signal sync
		logic energy; // Filtered energy
		logic sig; // Filtered signal
		logic strap_auto; // Latched strap
		logic strap_man; // Latched strap
		logic [31:0] rdata; // Read data
		logic [4:0] tx; // Tx enable+nibble
		logic [4:0] rx; // Rx valid+nibble
		logic crs; // Carrier
		logic col; // Collision
		logic irq; // Summary
	} plci_st_type;

	plci_st_type st_ff;
	plci_st_type nxt_st;

	logic setup_rd; // Read setup cycle
	logic acc_wr; // Write access edge
	logic flag_rd; // Flags read access
	logic [7:0] flag_set; // New events
	logic [7:0] flag_clr; // Bits reported
	logic restart_hit; // Restart written
	logic pdn; // Power-down wanted
	logic active; // Data path open
	logic unmapped; // Address not decoded
	logic [15:0] rd_word; // Read mux

	// Highest common ability wins
	function automatic logic [1:0] plci_resolve(
		input logic [15:0] a,
		input logic [15:0] p
	);
		logic [15:0] c;
		c = a & p;
		if (c[AB_100FD]) begin
			plci_resolve = 2'h3;
		end else if (c[AB_100HD]) begin
			plci_resolve = 2'h2;
		end else if (c[AB_10FD]) begin
			plci_resolve = 2'h1;
		end else begin
			plci_resolve = 2'h0;
		end
	endfunction : plci_resolve

	// Pause resolution, returns rx then tx
	function automatic logic [1:0] plci_pause(
		input logic [15:0] a,
		input logic [15:0] p
	);
		logic both;
		both = a[ADV_SYM] & p[ADV_SYM];
		plci_pause = {
			both | (a[ADV_SYM] & a[ADV_ASYM] & !p[ADV_SYM]
				& p[ADV_ASYM]),
			both | (!a[ADV_SYM] & a[ADV_ASYM] & p[ADV_SYM]
				& p[ADV_ASYM])
		};
	endfunction : plci_pause

	// Next-state logic
	always_comb begin
		nxt_st = st_ff;
		flag_set = 8'h00;
		rd_word = UNMAPPED;
		unmapped = 1'b0;
		setup_rd = psel & !penable & !pwrite;
		acc_wr = psel & penable & pwrite;
		flag_rd = psel & penable & !pwrite & (paddr == OFS_FLAGS);
		restart_hit = acc_wr & (paddr == OFS_BASIC)
			& pwdata[BC_RESTART];
		// Three stages, change once last two agree
		nxt_st.s_en = {st_ff.s_en[1:0], line_energy_seen};
		nxt_st.s_sig = {st_ff.s_sig[1:0], line_signal_ok};
		if (st_ff.s_en[1] == st_ff.s_en[2]) begin
			nxt_st.energy = st_ff.s_en[2];
		end
		if (st_ff.s_sig[1] == st_ff.s_sig[2]) begin
			nxt_st.sig = st_ff.s_sig[2];
		end
		flag_set[IRQ_ENERGY] = nxt_st.energy & !st_ff.energy;

		unique case (paddr)
			OFS_BASIC: rd_word = st_ff.basic;
			OFS_STATUS: rd_word = STATUS_FIX
				| {10'h000, st_ff.ancomp, 2'h0, st_ff.link, 2'h0};
			OFS_ID1: rd_word = ID_HI;
			OFS_ID2: rd_word = ID_LO;
			OFS_ADV: rd_word = st_ff.adv;
			OFS_PARTNER: rd_word = st_ff.partner;
			OFS_EXP: rd_word = {11'h000, st_ff.exp_pdf, 2'h0,
				st_ff.exp_page, st_ff.exp_lp_an};
			OFS_MODE: begin
				rd_word = st_ff.mode;
				rd_word[MODE_ENERGY] = st_ff.energy;
			end
			OFS_SPECIAL: rd_word = st_ff.special;
			OFS_FLAGS: rd_word = {8'h00, st_ff.flags};
			OFS_ENABLES: rd_word = st_ff.enables;
			OFS_FPAUSE: rd_word = {10'h000, st_ff.rxfc,
				st_ff.txfc, st_ff.fdx, st_ff.fpause};
			OFS_SYSIRQ: rd_word = 16'h0000;
			default: unmapped = 1'b1;
		endcase
		// Capture in setup so data comes from a flop
		if (setup_rd) begin
			nxt_st.rdata = {16'h0000, rd_word};
			if (paddr == OFS_SYSIRQ) begin
				nxt_st.rdata = 32'h00000000;
				nxt_st.rdata[SYS_BIT] = st_ff.irq;
			end
		end

		// Register writes, unmapped ones dropped
		if (acc_wr) begin
			unique case (paddr)
				OFS_BASIC: nxt_st.basic = pwdata[15:0] & BASIC_WMASK;
				// only advert writes change pause bits
				OFS_ADV: nxt_st.adv = (pwdata[15:0] & ADV_WMASK)
					| (st_ff.adv & ~ADV_WMASK);
				OFS_MODE: nxt_st.mode[MODE_EDPD] = pwdata[MODE_EDPD];
				OFS_SPECIAL: nxt_st.special = pwdata[15:0] & SP_WMASK;
				OFS_ENABLES: nxt_st.enables = pwdata[15:0] & EN_WMASK;
				OFS_FPAUSE: nxt_st.fpause = pwdata[2:0];
				default: nxt_st.basic = st_ff.basic;
			endcase
		end
		// Restart is self-clearing
		nxt_st.basic[BC_RESTART] = 1'b0;

		pdn = st_ff.basic[BC_PDOWN]
			| (st_ff.mode[MODE_EDPD] & !st_ff.energy);

		// Negotiation state machine
		unique case (st_ff.an)
			AN_PDOWN: begin
				if (!pdn) begin
					nxt_st.an = AN_ABILITY;
				end
			end
			AN_OFF: begin
				nxt_st.spd = st_ff.basic[BC_SPEED];
				nxt_st.fdx = st_ff.basic[BC_DUPLEX];
				nxt_st.link = st_ff.sig;
				flag_set[IRQ_LDOWN] = st_ff.link & !st_ff.sig;
			end
			AN_BREAK: begin
				// hold off for the break interval
				nxt_st.cnt = st_ff.cnt + 32'h00000001;
				if (st_ff.cnt >= BRK_LAST) begin
					nxt_st.an = AN_ABILITY;
				end
			end
			AN_ABILITY: begin
				if (flp_page_valid) begin
					nxt_st.partner = flp_page_word;
					nxt_st.exp_lp_an = 1'b1;
					nxt_st.exp_page = 1'b1;
					flag_set[IRQ_PAGE] = 1'b1;
					flag_set[IRQ_RFAULT] = flp_page_word[LP_RFAULT];
					nxt_st.an = AN_ACK;
				end else if (pd_fault) begin
					nxt_st.exp_pdf = 1'b1;
					flag_set[IRQ_PDFAULT] = 1'b1;
				end else if (pd_sym100 | pd_nlp10) begin
					nxt_st.spd = pd_sym100;
					nxt_st.fdx = 1'b0;
					nxt_st.exp_lp_an = 1'b0;
					nxt_st.partner = 16'h0000;
					nxt_st.partner[AB_100HD] = pd_sym100;
					nxt_st.partner[AB_10HD] = !pd_sym100;
					nxt_st.link = 1'b1;
					nxt_st.ancomp = 1'b1;
					flag_set[IRQ_ANDONE] = 1'b1;
					nxt_st.an = AN_LINK;
				end
			end
			AN_ACK: begin
				if (flp_ack_seen) begin
					{nxt_st.spd, nxt_st.fdx} =
						plci_resolve(st_ff.adv, st_ff.partner);
					nxt_st.link = 1'b1;
					nxt_st.ancomp = 1'b1;
					flag_set[IRQ_LPACK] = 1'b1;
					flag_set[IRQ_ANDONE] = 1'b1;
					nxt_st.an = AN_LINK;
				end
			end
			AN_LINK: begin
				if (!st_ff.sig) begin
					nxt_st.link = 1'b0;
					nxt_st.ancomp = 1'b0;
					flag_set[IRQ_LDOWN] = 1'b1;
					nxt_st.an = AN_ABILITY;
				end
			end
			// Unused codes fall back to negotiating
			default: nxt_st.an = AN_ABILITY;
		endcase

		// Overrides, power-down first
		if (pdn) begin
			nxt_st.an = AN_PDOWN;
			nxt_st.link = 1'b0;
			nxt_st.ancomp = 1'b0;
		end else if (restart_hit & st_ff.basic[BC_AN]) begin
			nxt_st.an = AN_BREAK;
			nxt_st.cnt = 32'h00000000;
			nxt_st.link = 1'b0;
			nxt_st.ancomp = 1'b0;
		end else if (!st_ff.basic[BC_AN]) begin
			nxt_st.an = AN_OFF;
		end else if (st_ff.an == AN_OFF) begin
			nxt_st.an = AN_ABILITY;
			nxt_st.link = 1'b0;
		end

		// sticky flags, only reported bits clear
		flag_clr = flag_rd ? st_ff.rdata[7:0] : 8'h00;
		nxt_st.flags = (st_ff.flags & ~flag_clr) | flag_set;
		nxt_st.irq = |(nxt_st.flags & nxt_st.enables[7:0]);

		if (!st_ff.basic[BC_AN] | st_ff.fpause[FP_SEL]) begin
			{nxt_st.rxfc, nxt_st.txfc} = st_ff.fpause[2:1];
		end else if (st_ff.fdx) begin
			{nxt_st.rxfc, nxt_st.txfc} =
				plci_pause(st_ff.adv, st_ff.partner);
		end else begin
			{nxt_st.rxfc, nxt_st.txfc} = 2'h0;
		end

		// data halted during break and power-down
		active = st_ff.link & (st_ff.an != AN_BREAK) & !pdn;
		// enable and nibble copied whenever active, enable high or not
		nxt_st.tx = active ? {mac_tx_en, mac_txd} : 5'h00;
		nxt_st.rx = active ? {line_rx_dv, line_rxd} : 5'h00;
		if (st_ff.fdx) begin
			nxt_st.crs = active & line_rx_dv;
			nxt_st.col = 1'b0;
		end else begin
			// carrier both ways, collision on overlap
			nxt_st.crs = active & (mac_tx_en | line_rx_dv);
			nxt_st.col = active & mac_tx_en & line_rx_dv;
		end
	end

	// State register, straps caught at reset
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_ff <= '0;
			st_ff.an <= AN_ABILITY;
			st_ff.basic <= BASIC_RST;
			st_ff.adv <= ADV_RST | {4'h0, strap_asym_pause,
				strap_sym_pause, 10'h000};
			st_ff.strap_auto <= strap_auto_mdix;
			st_ff.strap_man <= strap_manual_mdix;
			st_ff.exp_lp_an <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Output drive
	assign prdata = st_ff.rdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign {line_tx_en, line_txd} = st_ff.tx;
	assign {mii_rx_dv, mii_rxd} = st_ff.rx;
	assign mii_crs = st_ff.crs;
	assign mii_col = st_ff.col;
	assign rxclk_recovered = st_ff.sig;
	assign speed_100 = st_ff.spd;
	assign full_duplex = st_ff.fdx;
	assign link_up = st_ff.link;
	assign port_fc_tx = st_ff.txfc;
	assign port_fc_rx = st_ff.rxfc;
	assign auto_mdix_en = st_ff.special[SP_OVR]
		? st_ff.special[SP_AUTO] : st_ff.strap_auto;
	assign mdix_cross = st_ff.special[SP_OVR]
		? st_ff.special[SP_MAN] : st_ff.strap_man;
	assign port_power_down = st_ff.an == AN_PDOWN;
	assign port_irq = st_ff.irq;

	// Checks on the port behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_break_hold: assert property (
		(st_ff.an == AN_BREAK) && (st_ff.cnt < BRK_LAST) && !pdn
		&& !restart_hit && st_ff.basic[BC_AN]
		|=> st_ff.an == AN_BREAK)
		else $error("break interval ended early");
	a_break_quiet: assert property (
		st_ff.an == AN_BREAK |=> !line_tx_en && !mii_rx_dv)
		else $error("data moved during break");
	a_full_nocol: assert property (
		st_ff.fdx |=> !mii_col)
		else $error("collision in full duplex");
	a_half_col: assert property (
		!st_ff.fdx && active && mac_tx_en && line_rx_dv
		|=> mii_col && mii_crs)
		else $error("missed half duplex collision");
	a_irq_clear: assert property (
		flag_rd && (flag_set == 8'h00)
		&& ((st_ff.flags & ~st_ff.rdata[7:0]) == 8'h00)
		|=> !port_irq)
		else $error("flags read left interrupt set");
	a_flag_sticky: assert property (
		!flag_rd |=> (st_ff.flags & $past(st_ff.flags))
		== $past(st_ff.flags))
		else $error("flag lost without read");
	a_pd_half: assert property (
		st_ff.an == AN_ABILITY && !flp_page_valid && !pd_fault
		&& (pd_sym100 || pd_nlp10) && !pdn && !restart_hit
		&& st_ff.basic[BC_AN]
		|=> !st_ff.exp_lp_an && !full_duplex && link_up
		&& speed_100 == $past(pd_sym100))
		else $error("parallel detect result wrong");
	a_forced_mode: assert property (
		st_ff.an == AN_OFF && !pdn
		|=> speed_100 == $past(st_ff.basic[BC_SPEED])
		&& full_duplex == $past(st_ff.basic[BC_DUPLEX]))
		else $error("forced mode not applied");
	a_fc_manual: assert property (
		st_ff.fpause[FP_SEL]
		|=> {port_fc_rx, port_fc_tx} == $past(st_ff.fpause[2:1]))
		else $error("forced pause not applied");
	a_unmapped_rd: assert property (
		setup_rd && unmapped |=> prdata == {16'h0000, UNMAPPED})
		else $error("unmapped read not ffff");
	a_mdix_ovr: assert property (
		st_ff.special[SP_OVR] |-> auto_mdix_en
		== st_ff.special[SP_AUTO])
		else $error("crossover override ignored");
	a_pdown_hold: assert property (
		st_ff.basic[BC_PDOWN] |=> port_power_down && !link_up)
		else $error("port up while powered down");

	c_break: cover property (st_ff.an == AN_BREAK ##1
		st_ff.an == AN_ABILITY);
	c_pd_link: cover property (st_ff.an == AN_ABILITY ##1
		st_ff.an == AN_LINK && !st_ff.exp_lp_an);
	c_ack_link: cover property (st_ff.an == AN_ACK ##1
		st_ff.an == AN_LINK);
	c_irq_clear: cover property (port_irq && flag_rd ##1 !port_irq);
endmodule : plci_port

/* File: tb/plci_mac_model.sv */
`timescale 1ns/100ps
// Switch MAC stand-in on the nibble interface
module plci_mac_model #(
	parameter int HOLD = 8
) (
	input wire logic ref_clk, // 200 MHz clock
	input wire logic start, // Begin a frame
	input wire logic [3:0] nibbles, // Frame length
	output logic mac_tx_en, // Transmit enable
	output logic [3:0] mac_txd, // Transmit nibble
	input wire logic mii_rx_dv, // Receive valid
	input wire logic [3:0] mii_rxd, // Receive nibble
	output logic [3:0] last_rxd // Last nibble taken
);
	int left = 0; // Nibbles still to send
	int hold = 0; // Cycles on this nibble
	initial begin
		mac_tx_en = 1'b0;
		mac_txd = 4'h0;
		last_rxd = 4'h0;
	end
	// nibbles with enable
	// HOLD of 8 gives the 25 MHz nibble rate
	always @(posedge ref_clk) begin
		if (start) begin
			left <= nibbles;
			hold <= 0;
		end else if (left > 0) begin
			mac_tx_en <= 1'b1;
			if (hold == HOLD - 1) begin
				hold <= 0;
				left <= left - 1;
				mac_txd <= mac_txd + 4'h1;
			end else begin
				hold <= hold + 1;
			end
		end else begin
			// Idle bus toggles so stale data never matches
			mac_tx_en <= 1'b0;
			mac_txd <= ~mac_txd;
		end
		if (mii_rx_dv)
			last_rxd <= mii_rxd;
	end
endmodule : plci_mac_model

/* File: tb/tb_plci_port.sv */
`timescale 1ns/100ps
module tb_plci_port;
	import plci_pkg::*;
	logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, start = 0;
	logic strap_sym_pause = 1, strap_asym_pause = 0;
	logic strap_auto_mdix = 0, strap_manual_mdix = 1;
	logic line_energy_seen = 1, line_signal_ok = 1;
	logic flp_page_valid = 0, flp_ack_seen = 0;
	logic [15:0] flp_page_word = 16'h0;
	logic pd_sym100 = 0, pd_nlp10 = 0, pd_fault = 0;
	logic mac_tx_en, line_rx_dv = 0, line_tx_en, mii_rx_dv, mii_crs;
	logic [3:0] mac_txd, line_rxd = 4'h5, line_txd, mii_rxd, last_rxd;
	logic mii_col, rxclk_recovered, speed_100, full_duplex, link_up;
	logic port_fc_tx, port_fc_rx, auto_mdix_en, mdix_cross;
	logic port_power_down, port_irq;
	int miscompares = 0;
	int n_tests = 0;
	// Short break interval keeps the run brief
	plci_port #(.BREAK_CYCLES(20)) plci_port_inst (.ref_clk, .srst,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .strap_sym_pause, .strap_asym_pause, .strap_auto_mdix,
		.strap_manual_mdix, .line_energy_seen, .line_signal_ok,
		.flp_page_valid, .flp_page_word, .flp_ack_seen, .pd_sym100,
		.pd_nlp10, .pd_fault, .mac_tx_en, .mac_txd, .line_rx_dv,
		.line_rxd, .line_tx_en, .line_txd, .mii_rx_dv, .mii_rxd, .mii_crs,
		.mii_col, .rxclk_recovered, .speed_100, .full_duplex, .link_up,
		.port_fc_tx, .port_fc_rx, .auto_mdix_en, .mdix_cross,
		.port_power_down, .port_irq);
	plci_mac_model plci_mac_model_inst (.ref_clk, .start, .nibbles(4'h4),
		.mac_tx_en, .mac_txd, .mii_rx_dv, .mii_rxd, .last_rxd);
	always #2.5 ref_clk = ~ref_clk;
	task summarize;
		$display("counts: %0d checks, %0d mismatches", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	// APB transfer; one idle edge after keeps strobes single per step
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task t_reset;
		apb(0, OFS_BASIC, 0);
		chk(rd, 32'h3100);
		apb(0, OFS_ADV, 0);
		chk(rd, 32'h05e1);
		apb(1, 8'h20, 32'h1234);
		apb(0, 8'h20, 0);
		chk(rd, 32'hffff);
		chk(pslverr, 0);
		chk({auto_mdix_en, mdix_cross}, 2'b01);
		apb(0, OFS_FLAGS, 0);
		chk(rd & 32'h80, 32'h80);
		$display("test reset done");
	endtask : t_reset
	task t_fault;
		apb(1, OFS_ENABLES, 32'h40);
		pd_fault <= 1'b1;
		cyc(1);
		pd_fault <= 1'b0;
		cyc(2);
		chk(port_irq, 0);
		apb(0, OFS_EXP, 0);
		chk(rd & 32'h10, 32'h10);
		apb(0, OFS_FLAGS, 0);
		chk(rd & 32'h04, 32'h04);
		$display("test fault done");
	endtask : t_fault
	task t_pdet;
		pd_sym100 <= 1'b1;
		cyc(1);
		pd_sym100 <= 1'b0;
		cyc(2);
		chk({link_up, speed_100, full_duplex}, 3'b110);
		chk(port_irq, 1);
		apb(0, OFS_STATUS, 0);
		chk(rd, {16'h0000, STATUS_FIX | 16'h0024});
		apb(0, OFS_EXP, 0);
		chk(rd & 32'h01, 0);
		apb(0, OFS_PARTNER, 0);
		chk(rd, 32'h0080);
		apb(0, OFS_SYSIRQ, 0);
		chk(rd[SYS_PORT1_BIT], 1);
		apb(0, OFS_FLAGS, 0);
		chk(rd & 32'h40, 32'h40);
		cyc(2);
		chk(port_irq, 0);
		$display("test parallel done");
	endtask : t_pdet
	// Duplex check: rx while transmitting, then tx alone
	task duplex(input logic half);
		start <= 1'b1;
		cyc(1);
		start <= 1'b0;
		line_rx_dv <= 1'b1;
		cyc(5);
		chk({mii_crs, mii_col}, {1'b1, half});
		chk(mii_rxd, line_rxd);
		chk(line_txd, mac_txd);
		line_rx_dv <= 1'b0;
		cyc(3);
		chk({mii_crs, mii_col, line_tx_en}, {half, 2'b01});
		cyc(30);
		chk(last_rxd, line_rxd);
		chk(rxclk_recovered, 1);
	endtask : duplex
	task t_pause;
		apb(1, OFS_FPAUSE, 32'h7);
		cyc(2);
		chk({port_fc_tx, port_fc_rx}, 2'b11);
		apb(0, OFS_ADV, 0);
		chk(rd, 32'h05e1);
		apb(1, OFS_ADV, 32'h0de0);
		apb(0, OFS_ADV, 0);
		chk(rd, 32'h0de1);
		$display("test pause done");
	endtask : t_pause
	task t_restart;
		apb(1, OFS_BASIC, 32'h1200);
		line_rx_dv <= 1'b1;
		cyc(2);
		chk({link_up, mii_rx_dv}, 2'b00);
		line_rx_dv <= 1'b0;
		cyc(25);
		flp_page_word <= 16'h0101;
		flp_page_valid <= 1'b1;
		cyc(1);
		flp_page_valid <= 1'b0;
		cyc(1);
		flp_ack_seen <= 1'b1;
		cyc(1);
		flp_ack_seen <= 1'b0;
		cyc(2);
		chk({link_up, speed_100, full_duplex}, 3'b111);
		line_signal_ok <= 1'b0;
		cyc(8);
		chk(link_up, 0);
		line_signal_ok <= 1'b1;
		cyc(8);
		// Legacy 10M partner after the signal came back
		pd_nlp10 <= 1'b1;
		cyc(1);
		pd_nlp10 <= 1'b0;
		cyc(2);
		chk({link_up, speed_100, full_duplex}, 3'b100);
		apb(0, OFS_PARTNER, 0);
		chk(rd, 32'h0020);
		$display("test restart done");
	endtask : t_restart
	task t_forced;
		apb(1, OFS_BASIC, 32'h2100);
		cyc(2);
		chk({speed_100, full_duplex}, 2'b11);
		duplex(1'b0);
		$display("test forced done");
	endtask : t_forced
	task t_mdix;
		apb(1, OFS_SPECIAL, 32'hc000);
		chk(auto_mdix_en, 1);
		apb(1, OFS_SPECIAL, 32'h8000);
		chk({auto_mdix_en, mdix_cross}, 2'b00);
		$display("test crossover done");
	endtask : t_mdix
	task t_pdown;
		apb(1, OFS_BASIC, 32'h2900);
		cyc(2);
		chk(port_power_down, 1);
		apb(0, OFS_ADV, 0);
		chk(rd, 32'h0de1);
		apb(1, OFS_BASIC, 32'h2100);
		cyc(2);
		chk(port_power_down, 0);
		// Energy-detect power-down, registers kept
		apb(1, OFS_MODE, 32'h2000);
		line_energy_seen <= 1'b0;
		cyc(8);
		chk(port_power_down, 1);
		apb(0, OFS_MODE, 0);
		chk(rd, 32'h2000);
		line_energy_seen <= 1'b1;
		cyc(8);
		chk(port_power_down, 0);
		apb(0, OFS_FLAGS, 0);
		chk(rd & 32'h80, 32'h80);
		$display("test power-down done");
	endtask : t_pdown
	// Main sequence
	initial begin
		cyc(20);
		srst <= 1'b0;
		cyc(1);
		t_reset();
		t_fault();
		t_pdet();
		duplex(1'b1);
		$display("test half duplex done");
		t_pause();
		t_restart();
		t_forced();
		t_mdix();
		t_pdown();
		summarize();
	end
	// Watchdog well past the expected run
	initial begin
		cyc(20000);
		miscompares++;
		summarize();
	end
endmodule : tb_plci_port
